// File: logic/status_out_pkg.sv
package status_out_pkg;
  // clock and times
  localparam longint CLK_HZ              = 10_000_000;
  localparam longint ALARM_DELAY_MS      = 300;
  localparam longint ALARM_DELAY_CYC_DEF = ALARM_DELAY_MS * CLK_HZ / 1000;
  localparam int     DLY_W               = 22;

  // quantities in 0.1 % units
  localparam int          LVL_W           = 16;
  localparam logic [15:0] LVL_OVERLOAD_RST = 16'h03e8;
  localparam logic [15:0] LVL_DEVIATION_RST = 16'h001e;
  localparam logic [15:0] LVL_TORQUE_MAX  = 16'h07d0;
  localparam logic [15:0] LVL_TORQUE_RST  = 16'h03e8;

  // control method codes: range that allows torque monitoring, and reset value
  localparam logic [2:0] METHOD_SLV      = 3'h3;
  localparam logic [2:0] METHOD_SLV_ZERO = 3'h5;
  localparam logic [2:0] METHOD_RST      = 3'h0;

  // function flags
  localparam int FLAG_OVL_ONE = 0;
  localparam int FLAG_OVL_TWO = 1;
  localparam int FLAG_DEV     = 2;
  localparam int FLAG_ALARM   = 3;
  localparam int FLAG_TORQUE  = 4;
  localparam int NFLAG        = 5;
  localparam int NTERM        = 5;

  // function select codes: 0 none, else flag index plus one
  localparam logic [2:0]  FSEL_NONE  = 3'h0;
  localparam logic [2:0]  FSEL_ALARM = 3'h4;
  localparam logic [17:0] ASSIGN_RST = {FSEL_ALARM, 15'h0000};

  // register byte offsets
  localparam logic [7:0] OFS_OVL_ONE = 8'h00;
  localparam logic [7:0] OFS_OVL_TWO = 8'h04;
  localparam logic [7:0] OFS_DEV    = 8'h08;
  localparam logic [7:0] OFS_TQ_FD  = 8'h0c;
  localparam logic [7:0] OFS_TQ_RR  = 8'h10;
  localparam logic [7:0] OFS_TQ_RD  = 8'h14;
  localparam logic [7:0] OFS_TQ_FR  = 8'h18;
  localparam logic [7:0] OFS_CTRL   = 8'h1c;
  localparam logic [7:0] OFS_ASSIGN = 8'h20;
  localparam logic [7:0] OFS_FLAGS  = 8'h24;
  localparam logic [7:0] OFS_INT_ST = 8'h28;
  localparam logic [7:0] OFS_INT_MK = 8'h2c;

  // control register fields
  localparam int CTRL_METHOD_LSB = 0;
  localparam int CTRL_POL_BIT    = 3;

  // torque quadrant index
  localparam int Q_FWD_DRIVE = 0;
  localparam int Q_REV_REGEN = 1;
  localparam int Q_REV_DRIVE = 2;
  localparam int Q_FWD_REGEN = 3;
endpackage : status_out_pkg

// File: logic/drive_status_output_logic.sv
// Operation
// - overload warnings one and two assert while current exceeds their own level.
// - overload comparison runs in driving and in regenerative braking alike.
// - transistor outputs are active low, pulling toward common when asserted.
// - both overload levels reset to 100 % of rated current.
// - loop error is the absolute difference of setpoint and process variable.
// - deviation warning asserts while loop error exceeds the deviation level.
// - deviation level resets to 3 % and is writable.
// - fault alarm is active while tripped on a fault, inactive once cleared.
// - fault alarm is assignable to any output; relay carries it by default.
// - normally closed alarm contact closes under 2 s after power up.
// - alarm output follows the internal fault alarm after 300 ms.
// - contact polarity setting inverts the relay contact logic.
// - relay rests normal in run or stop, opposite in trip or unpowered.
// - over-torque asserts when torque exceeds the level of the present quadrant.
// - each quadrant torque level holds 0 to 200 %.
// - over-torque valid only for control methods 03, 04 and 05.
// - over-torque only reports; it never alters the torque.
`timescale 1ns/100ps
module drive_status_output_logic
  import status_out_pkg::*;
#(
  parameter int unsigned ALARM_DELAY_CYC = int'(ALARM_DELAY_CYC_DEF)
) (
  // clock, reset, enable
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // measured quantities in 0.1 % units, then rotation, regen and trip state bits
  input  wire logic [LVL_W-1:0]  output_current,
  input  wire logic [LVL_W-1:0]  loop_setpoint,
  input  wire logic [LVL_W-1:0]  loop_feedback,
  input  wire logic [LVL_W-1:0]  torque_estimate,
  input  wire logic              rotation_fwd,
  input  wire logic              regenerating,
  input  wire logic              fault_trip,
  // status pins
  output logic [NTERM-1:0]       term_pull_out,
  output logic [NTERM-1:0]       term_pull_oe,
  output logic                   relay_coil_on,
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [LVL_W-1:0]        ovl_one_lvl;
    logic [LVL_W-1:0]        ovl_two_lvl;
    logic [LVL_W-1:0]        dev_lvl;
    logic [3:0][LVL_W-1:0]   tq_lvl;
    logic [2:0]              method;
    logic                    pol;
    logic [17:0]             assign_sel;
    logic [NFLAG-1:0]        flags;
    logic [NFLAG-1:0]        int_st;
    logic [NFLAG-1:0]        int_mk;
    logic                    alm_dly;
    logic [DLY_W-1:0]        alm_cnt;
    logic                    wr_pend;
    logic [7:0]              wr_addr;
    logic [31:0]             hrdata;
    logic                    hready;
    logic                    irq;
    logic [NTERM-1:0]        term_oe;
    logic                    relay;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(ALARM_DELAY_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // pick the flag that a 3-bit function code names
  function automatic logic sel_func(input logic [2:0] code, input logic [NFLAG-1:0] fl);
    logic r;
    r = 1'b0;
    if (code != FSEL_NONE && int'(code) <= NFLAG) begin
      r = fl[int'(code) - 1];
    end
    return r;
  endfunction : sel_func

  // torque level write saturates at the top of the range
  function automatic logic [LVL_W-1:0] clamp_tq(input logic [31:0] d);
    logic [LVL_W-1:0] r;
    r = (d > 32'(LVL_TORQUE_MAX)) ? LVL_TORQUE_MAX : d[LVL_W-1:0];
    return r;
  endfunction : clamp_tq

  ////////////////////////////////////////////////////////////////////////////////
  logic [LVL_W-1:0] loop_err;
  logic [1:0]       quad;
  logic             method_ok;
  logic [NFLAG-1:0] flags_new;
  logic [NFLAG-1:0] rise;
  logic             take;

  always_comb begin
    st_nxt = st_r;
    loop_err = (loop_setpoint > loop_feedback) ? loop_setpoint - loop_feedback
                                               : loop_feedback - loop_setpoint;
    if (rotation_fwd) begin
      quad = regenerating ? 2'(Q_FWD_REGEN) : 2'(Q_FWD_DRIVE);
    end else begin
      quad = regenerating ? 2'(Q_REV_REGEN) : 2'(Q_REV_DRIVE);
    end
    method_ok = st_r.method >= METHOD_SLV && st_r.method <= METHOD_SLV_ZERO;

    // all but the torque compare independent of drive or regen state
    flags_new[FLAG_OVL_ONE] = output_current > st_r.ovl_one_lvl;
    flags_new[FLAG_OVL_TWO] = output_current > st_r.ovl_two_lvl;
    flags_new[FLAG_DEV]     = loop_err > st_r.dev_lvl;
    flags_new[FLAG_ALARM]   = st_r.alm_dly;
    flags_new[FLAG_TORQUE]  = method_ok && (torque_estimate > st_r.tq_lvl[quad]);
    st_nxt.flags = flags_new;
    rise = flags_new & ~st_r.flags;

    // alarm follows the trip level after a settled delay
    if (fault_trip != st_r.alm_dly) begin
      if (st_r.alm_cnt >= DLY_LAST) begin
        st_nxt.alm_dly = fault_trip;
        st_nxt.alm_cnt = '0;
      end else begin
        st_nxt.alm_cnt = st_r.alm_cnt + DLY_W'(1);
      end
    end else begin
      st_nxt.alm_cnt = '0;
    end

    // terminals pull low while their function is true
    for (int t = 0; t < NTERM; t++) begin
      st_nxt.term_oe[t] = sel_func(st_r.assign_sel[3*t +: 3], flags_new);
    end
    // relay energised means contacts in their normal position
    st_nxt.relay = sel_func(st_r.assign_sel[17:15], flags_new) == st_r.pol;

    // ahb-lite: zero wait, write lands in the data phase
    take = hsel && htrans[1] && hready;
    st_nxt.hready = 1'b1;
    st_nxt.wr_pend = take && hwrite;
    if (take) begin
      st_nxt.wr_addr = haddr[7:0];
    end
    if (take && !hwrite) begin
      unique case (haddr[7:0])
        OFS_OVL_ONE: st_nxt.hrdata = 32'(st_r.ovl_one_lvl);
        OFS_OVL_TWO: st_nxt.hrdata = 32'(st_r.ovl_two_lvl);
        OFS_DEV:    st_nxt.hrdata = 32'(st_r.dev_lvl);
        OFS_TQ_FD:  st_nxt.hrdata = 32'(st_r.tq_lvl[Q_FWD_DRIVE]);
        OFS_TQ_RR:  st_nxt.hrdata = 32'(st_r.tq_lvl[Q_REV_REGEN]);
        OFS_TQ_RD:  st_nxt.hrdata = 32'(st_r.tq_lvl[Q_REV_DRIVE]);
        OFS_TQ_FR:  st_nxt.hrdata = 32'(st_r.tq_lvl[Q_FWD_REGEN]);
        OFS_CTRL:   st_nxt.hrdata = 32'({st_r.pol, st_r.method});
        OFS_ASSIGN: st_nxt.hrdata = 32'(st_r.assign_sel);
        OFS_FLAGS:  st_nxt.hrdata = 32'(st_r.flags);
        OFS_INT_ST: st_nxt.hrdata = 32'(st_r.int_st);
        OFS_INT_MK: st_nxt.hrdata = 32'(st_r.int_mk);
        default:    st_nxt.hrdata = 32'h0000_0000;
      endcase
    end

    st_nxt.int_st = st_r.int_st;
    if (st_r.wr_pend) begin
      unique case (st_r.wr_addr)
        OFS_OVL_ONE: st_nxt.ovl_one_lvl = hwdata[LVL_W-1:0];
        OFS_OVL_TWO: st_nxt.ovl_two_lvl = hwdata[LVL_W-1:0];
        OFS_DEV:    st_nxt.dev_lvl = hwdata[LVL_W-1:0];
        OFS_TQ_FD:  st_nxt.tq_lvl[Q_FWD_DRIVE] = clamp_tq(hwdata);
        OFS_TQ_RR:  st_nxt.tq_lvl[Q_REV_REGEN] = clamp_tq(hwdata);
        OFS_TQ_RD:  st_nxt.tq_lvl[Q_REV_DRIVE] = clamp_tq(hwdata);
        OFS_TQ_FR:  st_nxt.tq_lvl[Q_FWD_REGEN] = clamp_tq(hwdata);
        OFS_CTRL: begin
          st_nxt.method = hwdata[CTRL_METHOD_LSB +: 3];
          st_nxt.pol    = hwdata[CTRL_POL_BIT];
        end
        OFS_ASSIGN: st_nxt.assign_sel = hwdata[17:0];
        OFS_INT_ST: st_nxt.int_st = st_r.int_st & ~hwdata[NFLAG-1:0];
        OFS_INT_MK: st_nxt.int_mk = hwdata[NFLAG-1:0];
        default: ;
      endcase
    end
    // a new event wins over a clear in the same cycle
    st_nxt.int_st = st_nxt.int_st | rise;
    st_nxt.irq = |(st_nxt.int_st & st_nxt.int_mk);
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r            <= '0;
      st_r.ovl_one_lvl <= LVL_OVERLOAD_RST;
      st_r.ovl_two_lvl <= LVL_OVERLOAD_RST;
      st_r.dev_lvl    <= LVL_DEVIATION_RST;
      st_r.tq_lvl     <= {4{LVL_TORQUE_RST}};
      st_r.method     <= METHOD_RST;
      st_r.assign_sel <= ASSIGN_RST;
      st_r.alm_dly    <= 1'b1;
      st_r.hready     <= 1'b1;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign hrdata        = st_r.hrdata;
  assign hreadyout     = st_r.hready;
  assign hresp         = 1'b0;
  assign term_pull_out = '0;
  assign term_pull_oe  = st_r.term_oe;
  assign relay_coil_on = st_r.relay;
  assign irq           = st_r.irq;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  property p_ovl_one;
    @(posedge sys_clk) disable iff (!reset_n)
      $past(clk_en) |-> st_r.flags[FLAG_OVL_ONE] ==
        ($past(output_current) > $past(st_r.ovl_one_lvl));
  endproperty
  a_ovl_one: assert property (p_ovl_one) else $error("overload one flag wrong");

  property p_ovl_two;
    @(posedge sys_clk) disable iff (!reset_n)
      (clk_en && regenerating && output_current > st_r.ovl_two_lvl) |=> st_r.flags[FLAG_OVL_TWO];
  endproperty
  a_ovl_two: assert property (p_ovl_two) else $error("overload two missed in regen");

  property p_dev;
    @(posedge sys_clk) disable iff (!reset_n)
      (clk_en && loop_feedback > loop_setpoint
       && loop_feedback - loop_setpoint > st_r.dev_lvl) |=> st_r.flags[FLAG_DEV];
  endproperty
  a_dev: assert property (p_dev) else $error("deviation flag missed");

  property p_otq_mode;
    @(posedge sys_clk) disable iff (!reset_n)
      (clk_en && (st_r.method < METHOD_SLV || st_r.method > METHOD_SLV_ZERO)) |=>
        !st_r.flags[FLAG_TORQUE];
  endproperty
  a_otq_mode: assert property (p_otq_mode) else $error("torque flag in bad mode");

  property p_tq_range;
    @(posedge sys_clk) disable iff (!reset_n)
      st_r.tq_lvl[0] <= LVL_TORQUE_MAX && st_r.tq_lvl[1] <= LVL_TORQUE_MAX
      && st_r.tq_lvl[2] <= LVL_TORQUE_MAX && st_r.tq_lvl[3] <= LVL_TORQUE_MAX;
  endproperty
  a_tq_range: assert property (p_tq_range) else $error("torque level out of range");

  property p_alarm_hold;
    @(posedge sys_clk) disable iff (!reset_n)
      (fault_trip != st_r.alm_dly && st_r.alm_cnt < DLY_LAST) |=> $stable(st_r.alm_dly);
  endproperty
  a_alarm_hold: assert property (p_alarm_hold) else $error("alarm changed too early");

  property p_relay;
    @(posedge sys_clk) disable iff (!reset_n)
      (clk_en && st_r.assign_sel[17:15] == FSEL_ALARM) |=>
        relay_coil_on == (st_r.flags[FLAG_ALARM] == $past(st_r.pol));
  endproperty
  a_relay: assert property (p_relay) else $error("relay polarity wrong");

  property p_term;
    @(posedge sys_clk) disable iff (!reset_n)
      (clk_en && st_r.assign_sel[2:0] == 3'(FLAG_OVL_ONE + 1)) |=>
        term_pull_oe[0] == st_r.flags[FLAG_OVL_ONE] && term_pull_out[0] == 1'b0;
  endproperty
  a_term: assert property (p_term) else $error("terminal not pulled low");

  property p_irq;
    @(posedge sys_clk) disable iff (!reset_n)
      irq == |(st_r.int_st & st_r.int_mk);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_ready;
    @(posedge sys_clk) disable iff (!reset_n)
      hreadyout && !hresp;
  endproperty
  a_ready: assert property (p_ready) else $error("slave stalled");

  property p_dev_fwd;
    @(posedge sys_clk) disable iff (!reset_n)
      (clk_en && loop_setpoint > loop_feedback
       && loop_setpoint - loop_feedback > st_r.dev_lvl) |=> st_r.flags[FLAG_DEV];
  endproperty
  a_dev_fwd: assert property (p_dev_fwd) else $error("deviation below setpoint missed");

  property p_otq_fd;
    @(posedge sys_clk) disable iff (!reset_n)
      (clk_en && st_r.method >= METHOD_SLV && st_r.method <= METHOD_SLV_ZERO
       && rotation_fwd && !regenerating
       && torque_estimate > st_r.tq_lvl[Q_FWD_DRIVE]) |=> st_r.flags[FLAG_TORQUE];
  endproperty
  a_otq_fd: assert property (p_otq_fd) else $error("torque flag missed");

  property p_otq_rr;
    @(posedge sys_clk) disable iff (!reset_n)
      (clk_en && !rotation_fwd && regenerating
       && torque_estimate <= st_r.tq_lvl[Q_REV_REGEN]) |=> !st_r.flags[FLAG_TORQUE];
  endproperty
  a_otq_rr: assert property (p_otq_rr) else $error("torque flag at level");

  property p_alarm_take;
    @(posedge sys_clk) disable iff (!reset_n)
      (clk_en && fault_trip != st_r.alm_dly && st_r.alm_cnt >= DLY_LAST) |=>
        st_r.alm_dly == $past(fault_trip);
  endproperty
  a_alarm_take: assert property (p_alarm_take) else $error("alarm did not follow");

  property p_alarm_flag;
    @(posedge sys_clk) disable iff (!reset_n)
      clk_en |=> st_r.flags[FLAG_ALARM] == $past(st_r.alm_dly);
  endproperty
  a_alarm_flag: assert property (p_alarm_flag) else $error("alarm flag wrong");

  property p_tq_clamp;
    @(posedge sys_clk) disable iff (!reset_n)
      (clk_en && st_r.wr_pend && st_r.wr_addr == OFS_TQ_FD && hwdata > 32'(LVL_TORQUE_MAX))
        |=> st_r.tq_lvl[Q_FWD_DRIVE] == LVL_TORQUE_MAX;
  endproperty
  a_tq_clamp: assert property (p_tq_clamp) else $error("torque level not saturated");

  property p_int_set;
    @(posedge sys_clk) disable iff (!reset_n)
      (clk_en && !st_r.flags[FLAG_OVL_ONE] && output_current > st_r.ovl_one_lvl) |=>
        st_r.int_st[FLAG_OVL_ONE];
  endproperty
  a_int_set: assert property (p_int_set) else $error("event not latched");

  property p_rd_level;
    @(posedge sys_clk) disable iff (!reset_n)
      (clk_en && hsel && htrans[1] && hready && !hwrite && haddr[7:0] == OFS_OVL_ONE) |=>
        hrdata == 32'($past(st_r.ovl_one_lvl));
  endproperty
  a_rd_level: assert property (p_rd_level) else $error("read data wrong");

endmodule : drive_status_output_logic

// File: test/status_sense_model.sv
`timescale 1ns/100ps
module status_sense_model
  import status_out_pkg::*;
(
  // open collector terminals and relay coil
  input  wire logic [NTERM-1:0] term_pull_out,
  input  wire logic [NTERM-1:0] term_pull_oe,
  input  wire logic             relay_coil_on,
  // levels seen by the controller
  output logic      [NTERM-1:0] term_level,
  output logic                  contact_a_closed,
  output logic                  contact_b_closed
);
  // external pull-up: a released terminal reads high
  always_comb begin
    for (int t = 0; t < NTERM; t++) begin
      term_level[t] = term_pull_oe[t] ? term_pull_out[t] : 1'b1;
    end
  end
  // form c contact set follows the coil
  assign contact_a_closed = relay_coil_on;
  assign contact_b_closed = ~relay_coil_on;
endmodule : status_sense_model

// File: test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import status_out_pkg::*;
  localparam int DLY = 8;
  logic        sys_clk = 0, reset_n = 0, hsel = 0, hwrite = 0, fault_trip = 0;
  logic        rotation_fwd = 1, regenerating = 0, clk_en = 1;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0]  htrans = 0;
  logic [15:0] cur = 0, sp = 0, fb = 0, tq = 0;
  logic        hreadyout, hresp, relay_coil_on, irq, con_a, con_b;
  logic [4:0]  term_pull_out, term_pull_oe, term_level;
  int          n_mismatch = 0, check_count = 0, cyc = 0;

  always #50 sys_clk = ~sys_clk;

  drive_status_output_logic #(.ALARM_DELAY_CYC(DLY)) drive_status_output_logic_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .output_current(cur),
    .loop_setpoint(sp), .loop_feedback(fb), .torque_estimate(tq),
    .rotation_fwd(rotation_fwd), .regenerating(regenerating), .fault_trip(fault_trip),
    .term_pull_out(term_pull_out), .term_pull_oe(term_pull_oe),
    .relay_coil_on(relay_coil_on), .irq(irq));

  status_sense_model status_sense_model_i (
    .term_pull_out(term_pull_out), .term_pull_oe(term_pull_oe),
    .relay_coil_on(relay_coil_on), .term_level(term_level),
    .contact_a_closed(con_a), .contact_b_closed(con_b));

  ////////////////////////////////////////////////////////////////////////////
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(name, rd, exp);
  endtask : rchk

  task drive(input logic [15:0] c, f, t, input logic fw, rg);
    @(posedge sys_clk);
    cur          <= c;
    sp           <= 16'h0064;
    fb           <= f;
    tq           <= t;
    rotation_fwd <= fw;
    regenerating <= rg;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : drive

  // active-low pins and the live flag register must agree
  task fchk(input string name, input logic [4:0] e);
    chk(name, term_level, {27'h0, ~e});
    rchk(name, OFS_FLAGS, {27'h0, e});
  endtask : fchk

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    chk("coil at power up", relay_coil_on, 32'h0);
    repeat (DLY + 4) @(negedge sys_clk);
    chk("coil settled", relay_coil_on, 32'h1);
    chk("contact b", con_b, 32'h0);
    chk("contact a", con_a, 32'h1);
    rchk("overload one reset", OFS_OVL_ONE, 32'd1000);
    rchk("overload two reset", OFS_OVL_TWO, 32'd1000);
    rchk("dev reset", OFS_DEV, 32'd30);
    rchk("assign reset", OFS_ASSIGN, 32'h00020000);
    rchk("unmapped", 8'h30, 32'h0);
    bus(1'b1, OFS_ASSIGN, 32'h000258d1);
    rchk("assign", OFS_ASSIGN, 32'h000258d1);
    bus(1'b1, OFS_OVL_ONE, 32'd500);
    bus(1'b1, OFS_OVL_TWO, 32'd800);
    drive(500, 100, 0, 1, 0); fchk("overload at level", 5'h00);
    drive(501, 100, 0, 1, 0); fchk("overload one over", 5'h01);
    drive(801, 100, 0, 1, 1); fchk("overload two regen", 5'h03);
    drive(0, 130, 0, 1, 0); fchk("dev at level", 5'h00);
    drive(0, 131, 0, 1, 0); fchk("dev above", 5'h04);
    drive(0, 69, 0, 1, 0); fchk("dev below", 5'h04);
    drive(0, 70, 0, 1, 0); fchk("dev inside", 5'h00);
    bus(1'b1, OFS_DEV, 32'd50);
    drive(0, 150, 0, 1, 0); fchk("dev new level", 5'h00);
    drive(0, 151, 0, 1, 0); fchk("dev new over", 5'h04);
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, OFS_CTRL, m);
      drive(0, 100, 1500, 1, 0);
      fchk("method", (m >= 3 && m <= 5) ? 5'h10 : 5'h00);
    end
    bus(1'b1, OFS_CTRL, 32'h4);
    for (int q = 0; q < 4; q++) bus(1'b1, OFS_TQ_FD + 8'(4 * q), 100 * (q + 1));
    for (int q = 0; q < 4; q++) begin
      drive(0, 100, 16'(100 * (q + 1)), q == 0 || q == 3, q[0]);
      fchk("quadrant level", 5'h00);
      drive(0, 100, 16'(100 * (q + 1) + 1), q == 0 || q == 3, q[0]);
      fchk("quadrant over", 5'h10);
    end
    bus(1'b1, OFS_TQ_FD, 32'd3000);
    rchk("torque saturate", OFS_TQ_FD, 32'd2000);
    bus(1'b1, OFS_TQ_FD, 32'd0);
    rchk("torque zero", OFS_TQ_FD, 32'd0);
    drive(0, 100, 0, 1, 0);
    bus(1'b1, OFS_INT_ST, 32'h1f);
    rchk("int clear", OFS_INT_ST, 32'h0);
    bus(1'b1, OFS_INT_MK, 32'h1);
    drive(501, 100, 0, 1, 0);
    chk("irq set", irq, 32'h1);
    rchk("int status", OFS_INT_ST, 32'h1);
    bus(1'b1, OFS_INT_ST, 32'h1);
    repeat (2) @(negedge sys_clk);
    chk("irq cleared", irq, 32'h0);
    drive(801, 100, 0, 1, 0);
    chk("irq masked", irq, 32'h0);
    rchk("int status two", OFS_INT_ST, 32'h2);
    bus(1'b1, OFS_INT_MK, 32'h2);
    repeat (2) @(negedge sys_clk);
    chk("irq unmasked", irq, 32'h1);
    bus(1'b1, OFS_INT_ST, 32'h2);
    drive(0, 100, 0, 1, 0);
    chk("irq off", irq, 32'h0);
    @(posedge sys_clk);
    clk_en <= 1'b0;
    drive(501, 100, 0, 1, 0);
    chk("frozen pin", term_level[0], 32'h1);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    repeat (2) @(negedge sys_clk);
    chk("thawed pin", term_level[0], 32'h0);
    @(posedge sys_clk);
    fault_trip <= 1'b1;
    repeat (5) @(negedge sys_clk);
    chk("alarm early", term_level[3], 32'h1);
    chk("coil early", relay_coil_on, 32'h1);
    repeat (8) @(negedge sys_clk);
    chk("alarm pin", term_level[3], 32'h0);
    chk("coil trip", relay_coil_on, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h8);
    repeat (2) @(negedge sys_clk);
    chk("coil inverted", relay_coil_on, 32'h1);
    @(posedge sys_clk);
    fault_trip <= 1'b0;
    repeat (DLY + 5) @(negedge sys_clk);
    chk("alarm cleared", term_level[3], 32'h1);
    chk("coil inverted idle", relay_coil_on, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h0);
    repeat (2) @(negedge sys_clk);
    chk("coil normal", relay_coil_on, 32'h1);
    end_sim;
  end
endmodule : tb_top
